/* rtl/spd_pkg.sv */
// Shared constants and types for the SPI data and DMA setup block
package spd_pkg;
    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam int WB_ADR_W = 18;
    localparam int IDX_W = 16;
    localparam logic [IDX_W-1:0] IDX_CTRL = 16'hC0D0;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 16'hC0D2;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hC0D4;
    localparam logic [IDX_W-1:0] IDX_DATA = 16'hC0D6;
    localparam logic [IDX_W-1:0] IDX_TX_BASE = 16'hC0D8;
    localparam logic [IDX_W-1:0] IDX_TX_LEN = 16'hC0DA;
    localparam logic [IDX_W-1:0] IDX_RX_BASE = 16'hC0DC;
    localparam logic [IDX_W-1:0] IDX_RX_LEN = 16'hC0DE;
    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int CNT_W = 11;
    localparam int BLEN_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam logic [BLEN_W-1:0] BLEN_RST = 3'h7;
    localparam logic [15:0] BASE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
    localparam int CTRL_DMA_MODE = 3;
    localparam int CTRL_TX_GO = 4;
    localparam int CTRL_RX_GO = 5;
    localparam int CTRL_RX_RDY = 8;
    localparam int CTRL_TX_FREE = 9;
    localparam int IRQ_W = 5;
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX_DONE = 1;
    localparam int IRQ_RX_OVF = 2;
    localparam int IRQ_TX_DMA = 3;
    localparam int IRQ_RX_DMA = 4;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        SPD_IDLE = 3'h1,
        SPD_TX_RD = 3'h2,
        SPD_RX_WR = 3'h4
    } spd_dma_st_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [DATA_W-1:0] wdata;
    } spd_mem_req_t;
    typedef struct packed {
        logic dma_mode;
        logic [BLEN_W-1:0] blen_m1;
    } spd_ctrl_t;
endpackage

/* rtl/spd_fifo.sv */
// Receive byte FIFO
`timescale 1ns/10ps
module spd_fifo
    import spd_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic push,
    input wire logic [W-1:0] din,
    input wire logic pop,
    output logic [W-1:0] dout,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    assign full = (cnt_q == (AW+1)'(DEPTH));
    assign empty = (cnt_q == '0);
    assign dout = mem_q[rd_q];
    // Push into a full FIFO is dropped even with a pop in the same cycle; caller reports it only when no pop
    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;

    always_comb begin
        wr_d = do_push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = do_pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (do_push) begin
            mem_q[wr_q] <= din;
        end
    end
endmodule

/* rtl/spd_shift.sv */
// SPI slave shift engine sampling the link clock on the system clock
`timescale 1ns/10ps
module spd_shift
    import spd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic [BLEN_W-1:0] blen_m1,
    input wire logic tx_load,
    input wire logic [DATA_W-1:0] tx_data,
    output logic tx_free,
    output logic tx_done,
    output logic rx_valid,
    output logic [DATA_W-1:0] rx_data
);
    // ************************************************************
    // Synchronisers; edges come from stages two and three only
    // ************************************************************
    logic [2:0] sck_q;
    logic [1:0] ss_q, mosi_q;
    logic rise, fall, sel;

    always_ff @(posedge clk) begin
        if (srst) begin
            sck_q <= '0;
            ss_q <= 2'h3;
            mosi_q <= '0;
        end else begin
            sck_q <= {sck_q[1:0], sck_i};
            ss_q <= {ss_q[0], ss_n_i};
            mosi_q <= {mosi_q[0], mosi_i};
        end
    end
    assign rise = sck_q[1] & ~sck_q[2];
    assign fall = ~sck_q[1] & sck_q[2];
    assign sel = ~ss_q[1];

    // ************************************************************
    // Shift state
    // ************************************************************
    logic [DATA_W-1:0] sr_q, sr_d, rsr_q, rsr_d, nxt_q, nxt_d, rxd_q, rxd_d;
    logic [BLEN_W-1:0] cnt_q, cnt_d;
    logic nxt_v_q, nxt_v_d, cur_v_q, cur_v_d, busy_q, busy_d;
    logic rxv_q, rxv_d, txd_q, txd_d, oe_q, oe_d;
    logic [DATA_W-1:0] rin;

    always_comb begin
        sr_d = sr_q;
        rsr_d = rsr_q;
        nxt_d = nxt_q;
        nxt_v_d = nxt_v_q;
        cur_v_d = cur_v_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        rxd_d = rxd_q;
        rxv_d = 1'b0;
        txd_d = 1'b0;
        oe_d = sel;
        rin = {rsr_q[DATA_W-2:0], mosi_q[1]};
        if (tx_load && !nxt_v_q) begin
            nxt_d = tx_data;
            nxt_v_d = 1'b1;
        end
        if (!busy_q && nxt_v_q && !cur_v_q) begin
            // Low bits go out MSB first, so align them to the top
            sr_d = nxt_q << (BLEN_RST - blen_m1);
            cur_v_d = 1'b1;
            nxt_v_d = 1'b0;
        end
        if (!sel) begin
            cnt_d = '0;
            busy_d = 1'b0;
        end else if (rise) begin
            rsr_d = rin;
            busy_d = 1'b1;
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == blen_m1) begin
                // Frame ends after the programmed number of bits
                rxd_d = rin & (8'hFF >> (BLEN_RST - blen_m1));
                rxv_d = 1'b1;
                txd_d = cur_v_q;
                cur_v_d = 1'b0;
                cnt_d = '0;
                busy_d = 1'b0;
                sr_d = '0;
            end
        end else if (fall && busy_q) begin
            sr_d = {sr_q[DATA_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sr_q <= '0;
            rsr_q <= '0;
            nxt_q <= '0;
            rxd_q <= '0;
            nxt_v_q <= 1'b0;
            cur_v_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= '0;
            rxv_q <= 1'b0;
            txd_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            sr_q <= sr_d;
            rsr_q <= rsr_d;
            nxt_q <= nxt_d;
            rxd_q <= rxd_d;
            nxt_v_q <= nxt_v_d;
            cur_v_q <= cur_v_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            rxv_q <= rxv_d;
            txd_q <= txd_d;
            oe_q <= oe_d;
        end
    end

    assign miso_o = sr_q[DATA_W-1];
    assign miso_oe = oe_q;
    assign tx_free = ~nxt_v_q;
    assign tx_done = txd_q;
    assign rx_valid = rxv_q;
    assign rx_data = rxd_q;
endmodule

/* rtl/spd_data_dma.sv */
// SPI data register, receive FIFO and DMA setup with Wishbone registers
`timescale 1ns/10ps
module spd_data_dma
    import spd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic spi_sck_i,
    input wire logic spi_ss_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    output spd_mem_req_t mem_req_o,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    input wire logic mem_ack_i
);
    // ************************************************************
    // Bus decode
    // ************************************************************
    logic ack_q, ack_d;
    logic acc, wr, rd;
    logic [IDX_W-1:0] idx;

    // One access per request; ack drops the cycle after it rose
    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;
    assign idx = wb_adr_i[WB_ADR_W-1:2];

    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    spd_ctrl_t ctrl_q, ctrl_d;
    logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [15:0] tx_base_q, tx_base_d, rx_base_q, rx_base_d;
    logic [CNT_W-1:0] tx_len_q, tx_len_d, rx_len_q, rx_len_d;
    logic [31:0] rdat_q, rdat_d;
    logic irq_q, irq_d;
    logic [15:0] wv;

    // ************************************************************
    // DMA state
    // ************************************************************
    spd_dma_st_t st_q, st_d;
    spd_mem_req_t mem_q, mem_d;
    logic tx_act_q, tx_act_d, rx_act_q, rx_act_d;
    logic [CNT_W-1:0] tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
    logic tx_dma_done, rx_dma_done;

    // ************************************************************
    // Shift engine and receive FIFO
    // ************************************************************
    logic sh_load, sh_free, sh_txdone, sh_rxv;
    logic [DATA_W-1:0] sh_rxd, sh_ld_data;
    logic f_pop, f_full, f_empty, sw_pop, dma_pop;
    logic [DATA_W-1:0] f_dout;
    logic sw_load, dma_load;

    spd_shift u_shift (
        .clk(clk),
        .srst(srst),
        .sck_i(spi_sck_i),
        .ss_n_i(spi_ss_n_i),
        .mosi_i(spi_mosi_i),
        .miso_o(spi_miso_o),
        .miso_oe(spi_miso_oe),
        .blen_m1(ctrl_q.blen_m1),
        .tx_load(sh_load),
        .tx_data(sh_ld_data),
        .tx_free(sh_free),
        .tx_done(sh_txdone),
        .rx_valid(sh_rxv),
        .rx_data(sh_rxd)
    );

    spd_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .push(sh_rxv),
        .din(sh_rxd),
        .pop(f_pop),
        .dout(f_dout),
        .full(f_full),
        .empty(f_empty)
    );

    // Software pops only while receive DMA is not draining the FIFO
    assign sw_pop = rd & (idx == IDX_DATA) & ~rx_act_q & ~f_empty;
    assign f_pop = sw_pop | dma_pop;
    // Writes while the holding byte is full are dropped, not queued
    assign sw_load = wr & (idx == IDX_DATA) & ~ctrl_q.dma_mode & sh_free;
    assign sh_load = sw_load | dma_load;
    assign sh_ld_data = dma_load ? mem_rdata_i : wb_dat_i[DATA_W-1:0];

    // ************************************************************
    // Register file next state
    // ************************************************************
    always_comb begin
        ack_d = acc;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        tx_base_d = tx_base_q;
        rx_base_d = rx_base_q;
        tx_len_d = tx_len_q;
        rx_len_d = rx_len_q;
        rdat_d = rdat_q;
        wv = '0;
        ev = '0;
        ev[IRQ_RX] = sh_rxv;
        ev[IRQ_TX_DONE] = sh_txdone;
        ev[IRQ_RX_OVF] = sh_rxv & f_full & ~f_pop;
        ev[IRQ_TX_DMA] = tx_dma_done;
        ev[IRQ_RX_DMA] = rx_dma_done;
        stat_d = stat_q | ev;
        if (wr) begin
            case (idx)
                IDX_CTRL: begin
                    wv = lane_merge({12'h000, ctrl_q}, wb_dat_i, wb_sel_i);
                    ctrl_d = wv[BLEN_W:0];
                end
                IDX_IRQ_STAT: begin
                    // New events win over a clearing write in the same cycle
                    wv = lane_merge(16'h0000, wb_dat_i, wb_sel_i);
                    stat_d = (stat_q & ~wv[IRQ_W-1:0]) | ev;
                end
                IDX_IRQ_MASK: begin
                    wv = lane_merge({11'h000, mask_q}, wb_dat_i, wb_sel_i);
                    mask_d = wv[IRQ_W-1:0];
                end
                IDX_TX_BASE: begin
                    tx_base_d = lane_merge(tx_base_q, wb_dat_i, wb_sel_i);
                end
                IDX_TX_LEN: begin
                    wv = lane_merge({5'h00, tx_len_q}, wb_dat_i, wb_sel_i);
                    tx_len_d = wv[CNT_W-1:0];
                end
                IDX_RX_BASE: begin
                    rx_base_d = lane_merge(rx_base_q, wb_dat_i, wb_sel_i);
                end
                IDX_RX_LEN: begin
                    wv = lane_merge({5'h00, rx_len_q}, wb_dat_i, wb_sel_i);
                    rx_len_d = wv[CNT_W-1:0];
                end
                default: begin
                    wv = '0;
                end
            endcase
        end
        if (rd) begin
            rdat_d = '0;
            case (idx)
                IDX_CTRL: begin
                    rdat_d[BLEN_W:0] = ctrl_q;
                    rdat_d[CTRL_TX_GO] = tx_act_q;
                    rdat_d[CTRL_RX_GO] = rx_act_q;
                    rdat_d[CTRL_RX_RDY] = ~f_empty;
                    rdat_d[CTRL_TX_FREE] = sh_free;
                end
                IDX_IRQ_STAT: rdat_d[IRQ_W-1:0] = stat_q;
                IDX_IRQ_MASK: rdat_d[IRQ_W-1:0] = mask_q;
                IDX_DATA: rdat_d[DATA_W-1:0] = f_empty ? '0 : f_dout;
                IDX_TX_BASE: rdat_d[15:0] = tx_base_q;
                IDX_TX_LEN: rdat_d[CNT_W-1:0] = tx_len_q;
                IDX_RX_BASE: rdat_d[15:0] = rx_base_q;
                IDX_RX_LEN: rdat_d[CNT_W-1:0] = rx_len_q;
                default: rdat_d = '0;
            endcase
        end
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            ctrl_q <= '{dma_mode: 1'b0, blen_m1: BLEN_RST};
            stat_q <= '0;
            mask_q <= '0;
            tx_base_q <= BASE_RST;
            rx_base_q <= BASE_RST;
            tx_len_q <= CNT_RST;
            rx_len_q <= CNT_RST;
            rdat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            tx_base_q <= tx_base_d;
            rx_base_q <= rx_base_d;
            tx_len_q <= tx_len_d;
            rx_len_q <= rx_len_d;
            rdat_q <= rdat_d;
            irq_q <= irq_d;
        end
    end

    // ************************************************************
    // DMA engine: one memory port shared, transmit served first
    // ************************************************************
    always_comb begin
        st_d = st_q;
        mem_d = mem_q;
        tx_act_d = tx_act_q;
        rx_act_d = rx_act_q;
        tx_idx_d = tx_idx_q;
        rx_idx_d = rx_idx_q;
        tx_dma_done = 1'b0;
        rx_dma_done = 1'b0;
        dma_pop = 1'b0;
        dma_load = 1'b0;
        if (wr && idx == IDX_CTRL && wb_sel_i[0] && ctrl_d.dma_mode) begin
            // Start resets the byte index and restarts a block in flight; a memory ack that cycle advances the index, a block at its length stops
            if (wb_dat_i[CTRL_TX_GO]) begin
                tx_act_d = 1'b1;
                tx_idx_d = '0;
            end
            if (wb_dat_i[CTRL_RX_GO]) begin
                rx_act_d = 1'b1;
                rx_idx_d = '0;
            end
        end
        case (st_q)
            SPD_IDLE: begin
                if (tx_act_q && tx_idx_q == tx_len_q) begin
                    tx_act_d = 1'b0;
                    tx_dma_done = 1'b1;
                end else if (tx_act_q && sh_free) begin
                    mem_d = '{req: 1'b1, we: 1'b0, addr: tx_base_q + {5'h00, tx_idx_q},
                              wdata: '0};
                    st_d = SPD_TX_RD;
                end else if (rx_act_q && rx_idx_q == rx_len_q) begin
                    rx_act_d = 1'b0;
                    rx_dma_done = 1'b1;
                end else if (rx_act_q && !f_empty) begin
                    mem_d = '{req: 1'b1, we: 1'b1, addr: rx_base_q + {5'h00, rx_idx_q},
                              wdata: f_dout};
                    dma_pop = 1'b1;
                    st_d = SPD_RX_WR;
                end
            end
            SPD_TX_RD: begin
                if (mem_ack_i) begin
                    mem_d.req = 1'b0;
                    dma_load = 1'b1;
                    tx_idx_d = tx_idx_q + 1'b1;
                    st_d = SPD_IDLE;
                end
            end
            SPD_RX_WR: begin
                if (mem_ack_i) begin
                    mem_d.req = 1'b0;
                    rx_idx_d = rx_idx_q + 1'b1;
                    st_d = SPD_IDLE;
                end
            end
            default: begin
                st_d = SPD_IDLE;
                mem_d.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= SPD_IDLE;
            mem_q <= '0;
            tx_act_q <= 1'b0;
            rx_act_q <= 1'b0;
            tx_idx_q <= '0;
            rx_idx_q <= '0;
        end else begin
            st_q <= st_d;
            mem_q <= mem_d;
            tx_act_q <= tx_act_d;
            rx_act_q <= rx_act_d;
            tx_idx_q <= tx_idx_d;
            rx_idx_q <= rx_idx_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = irq_q;
    assign mem_req_o = mem_q;
endmodule

/* dv/spd_data_dma_props.sv */
// Checker for the SPI data and DMA setup block
`timescale 1ns/10ps
module spd_data_dma_props
    import spd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic spi_ss_n_i,
    input wire logic spi_miso_oe,
    input wire spd_mem_req_t mem_req_o,
    input wire logic mem_ack_i
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire [15:0] idx = wb_adr_i[17:2];
    wire rd_ack = wb_ack_o && !wb_we_i;
    chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_data_low: assert property (rd_ack && idx == IDX_DATA |-> wb_dat_o[15:8] == 8'h00)
        else $error("data read upper byte not zero");
    chk_count_width: assert property (rd_ack && (idx == IDX_TX_LEN || idx == IDX_RX_LEN)
        |-> wb_dat_o[15:11] == 5'h00)
        else $error("count reserved bits not zero");
    // Two sync stages plus a register, so a short window is allowed
    chk_oe_on: assert property ($fell(spi_ss_n_i) |-> ##[1:5] spi_miso_oe)
        else $error("miso enable late");
    chk_oe_off: assert property (spi_ss_n_i [*6] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    chk_req_hold: assert property (mem_req_o.req && !mem_ack_i
        |=> mem_req_o.req && $stable(mem_req_o.addr))
        else $error("memory request not held");
    chk_req_drop: assert property (mem_req_o.req && mem_ack_i |=> !mem_req_o.req)
        else $error("memory request not dropped");
endmodule
bind spd_data_dma spd_data_dma_props u_props (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .spi_ss_n_i, .spi_miso_oe, .mem_req_o, .mem_ack_i);

/* dv/spd_spi_master.sv */
// Far-side SPI master model, mode 0
`timescale 1ns/10ps
module spd_spi_master (
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // Clock stands low between frames; miso taken just before each rise
    task automatic frame(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        // Put link edges 5 ns after the call time, clear of the rising edge unless called 5 ns before one
        #5;
        ss_n = 1'b0;
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = tx[i];
            #80;
            rx = {rx[6:0], miso};
            sck = 1'b1;
            #80;
            sck = 1'b0;
        end
        #160;
        ss_n = 1'b1;
        mosi = ~mosi;
        #160;
    endtask
endmodule

/* dv/tb_top.sv */
// Testbench for the SPI data and DMA setup block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top
    import spd_pkg::*;
;
    logic clk, srst, cyc, stb, we, mack, sck, ssn, mosi, miso, miso_oe, irq, ack;
    logic [3:0] sel;
    logic [WB_ADR_W-1:0] adr;
    logic [31:0] wdat, rdat;
    logic [DATA_W-1:0] mrd;
    spd_mem_req_t mreq;
    logic [15:0] q;
    logic [7:0] rx;
    logic [15:0] addrs[$];
    logic [7:0] wds[$];
    logic [15:0] ev[4] = '{16'hA5C3, 16'h07FF, 16'h5A3C, 16'h0401};
    int checks, miscompares, cyc_n;
    wire miso_w = miso_oe ? miso : 1'bz;
    spd_data_dma u_dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .spi_sck_i(sck), .spi_ss_n_i(ssn), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe(miso_oe), .mem_req_o(mreq), .mem_rdata_i(mrd), .mem_ack_i(mack));
    spd_spi_master u_mst (.sck(sck), .ss_n(ssn), .mosi(mosi), .miso(miso_w));
    // ************************************************************
    // Clock, memory responder, timeout, bus task
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        mack <= mreq.req && !mack;
        mrd <= 8'h40 + mreq.addr[7:0];
        if (mreq.req && mack) addrs.push_back(mreq.addr);
        if (mreq.req && mack && mreq.we) wds.push_back(mreq.wdata);
        cyc_n++;
        if (cyc_n == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Request held until ack is sampled high at a rising edge, released there
    task automatic wb(input logic w, input logic [15:0] i, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= {i, 2'b00};
        wdat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        {srst, cyc, stb, we, sel, adr, wdat, mrd, mack} = '0;
        srst = 1'b1;
        checks = 0;
        miscompares = 0;
        cyc_n = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wb(0, IDX_TX_BASE + 16'(2 * k), 0);
            `CHK("dma reset", 16'h0000, q)
            wb(1, IDX_TX_BASE + 16'(2 * k), ev[k]);
            wb(0, IDX_TX_BASE + 16'(2 * k), 0);
            `CHK("dma rw", ev[k], q)
        end
        wb(0, 16'h0001, 0);
        `CHK("unmapped", 16'h0000, q)
        wb(0, IDX_CTRL, 0);
        `CHK("ctrl length", 3'h7, q[2:0])
        $display("test registers done");
        wb(1, IDX_IRQ_MASK, 16'h0001);
        wb(1, IDX_DATA, 16'h00A5);
        u_mst.frame(8, 8'h30, rx);
        `CHK("miso byte", 8'hA5, rx)
        for (int k = 1; k < 9; k++) u_mst.frame(8, 8'(8'h30 + k), rx);
        repeat (10) @(posedge clk);
        `CHK("irq set", 1'b1, irq)
        wb(0, IDX_IRQ_STAT, 0);
        `CHK("status", 16'h0007, q)
        wb(0, IDX_CTRL, 0);
        `CHK("rx ready", 1'b1, q[CTRL_RX_RDY])
        for (int k = 0; k < 8; k++) begin
            wb(0, IDX_DATA, 0);
            `CHK("fifo", 16'(16'h0030 + k), q)
        end
        wb(0, IDX_CTRL, 0);
        `CHK("rx empty", 1'b0, q[CTRL_RX_RDY])
        wb(1, IDX_IRQ_MASK, 16'h0000);
        repeat (3) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        wb(1, IDX_IRQ_STAT, 16'h0007);
        wb(0, IDX_IRQ_STAT, 0);
        `CHK("status clear", 16'h0000, q)
        $display("test byte mode done");
        wb(1, IDX_CTRL, 16'h0003);
        wb(1, IDX_DATA, 16'h000B);
        u_mst.frame(4, 8'h0D, rx);
        `CHK("miso nibble", 8'h0B, rx)
        repeat (10) @(posedge clk);
        wb(0, IDX_DATA, 0);
        `CHK("rx nibble", 16'h000D, q)
        $display("test bit length done");
        wb(1, IDX_TX_BASE, 16'h0120);
        wb(1, IDX_TX_LEN, 16'h0002);
        wb(1, IDX_CTRL, 16'h001F);
        repeat (20) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            u_mst.frame(8, 8'(8'h50 + k), rx);
            `CHK("dma byte", 8'(8'h60 + k), rx)
        end
        repeat (20) @(posedge clk);
        `CHK("dma count", 2, addrs.size())
        `CHK("dma addr0", 16'h0120, addrs[0])
        `CHK("dma addr1", 16'h0121, addrs[1])
        wb(0, IDX_IRQ_STAT, 0);
        `CHK("dma done", 1'b1, q[IRQ_TX_DMA])
        $display("test transmit dma done");
        // The two bytes just received sit in the FIFO for the receive block
        wb(1, IDX_RX_BASE, 16'h0200);
        wb(1, IDX_RX_LEN, 16'h0002);
        wb(1, IDX_CTRL, 16'h002F);
        repeat (20) @(posedge clk);
        `CHK("rx dma count", 4, addrs.size())
        `CHK("rx dma addr0", 16'h0200, addrs[2])
        `CHK("rx dma addr1", 16'h0201, addrs[3])
        `CHK("rx dma byte0", 8'h50, wds[0])
        `CHK("rx dma byte1", 8'h51, wds[1])
        wb(0, IDX_IRQ_STAT, 0);
        `CHK("rx dma done", 1'b1, q[IRQ_RX_DMA])
        wb(0, IDX_CTRL, 0);
        `CHK("rx dma drained", 1'b0, q[CTRL_RX_RDY])
        $display("test receive dma done");
        report_and_stop();
    end
endmodule
